// ===== core/scir_pkg.sv
package scir_pkg;
  // register byte addresses on the serial control port
  localparam logic [14:0] ADDR_IFCFG   = 15'h0000;
  localparam logic [14:0] ADDR_OPMODE  = 15'h0002;
  localparam logic [14:0] ADDR_DEVCLS  = 15'h0003;
  localparam logic [14:0] ADDR_DEVID_H = 15'h0004;
  localparam logic [14:0] ADDR_DEVID_L = 15'h0005;
  localparam logic [14:0] ADDR_STEPCFG = 15'h0010;
  // interface_config fields
  localparam int          BIT_FULL_RESET = 7;
  localparam int          BIT_ASCEND     = 5;
  localparam int          BIT_SDO_FLAG   = 4;
  localparam logic [7:0]  IFCFG_RESET    = 8'h30;
  localparam logic [7:0]  IFCFG_RO_MASK  = 8'h10;
  localparam logic [7:0]  OPMODE_RESET   = 8'h00;
  localparam logic [7:0]  DEVCLS_RESET   = 8'h00;
  localparam logic [7:0]  STEPCFG_RESET  = 8'h00;
  localparam int          BIT_ADDR_FREEZE = 0;
  // operating modes
  localparam logic [1:0]  MODE_NORMAL    = 2'h0;
  localparam logic [1:0]  MODE_SHUTDOWN  = 2'h3;
  // reset settle time
  localparam int          CLK_PERIOD_NS  = 10;
  localparam int          RESET_TIME_NS  = 750;
  localparam int          RESET_CYCLES   = RESET_TIME_NS / CLK_PERIOD_NS;
  // serial frame: r/w bit, 15 address bits, then data bytes
  localparam int          HDR_BITS       = 16;

  typedef struct packed {
    logic        wrEn;
    logic [14:0] addr;
    logic [7:0]  wdata;
  } scir_acc_s;
endpackage

// ===== core/scir_spi_shift.sv
`timescale 1ns/1ns
`default_nettype none
// spi mode 0 slave front end, oversampled on clk; address steps per byte
module scir_spi_shift (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             sclkSync,
  input  wire logic             csSync_b,
  input  wire logic             sdiSync,
  input  wire logic             stepUp,
  input  wire logic             stepHold,
  input  wire logic [7:0]       rdata,
  output var  scir_pkg::scir_acc_s acc,
  output logic                  accStb,
  output logic                  sdoOut
);
  logic        sclkDly_reg, sclkDly_next;
  logic [4:0]  bitCnt_reg, bitCnt_next;
  logic        hdrDone_reg, hdrDone_next;
  logic        rdMode_reg, rdMode_next;
  logic [14:0] addr_reg, addr_next;
  logic [7:0]  shift_reg, shift_next;
  logic [7:0]  out_reg, out_next;
  logic        stb_reg, stb_next;
  logic [7:0]  wbyte_reg, wbyte_next;
  logic        step_reg, step_next;
  logic        rise;
  logic        fall;

  assign rise = sclkSync & ~sclkDly_reg;
  assign fall = ~sclkSync & sclkDly_reg;

  // frame decode; a byte completes on the eighth rising edge
  always_comb begin
    sclkDly_next = sclkSync;
    bitCnt_next  = bitCnt_reg;
    hdrDone_next = hdrDone_reg;
    rdMode_next  = rdMode_reg;
    addr_next    = addr_reg;
    shift_next   = shift_reg;
    out_next     = out_reg;
    stb_next     = 1'b0;
    wbyte_next   = wbyte_reg;
    step_next    = 1'b0;
    if (csSync_b) begin
      bitCnt_next  = 5'h00;
      hdrDone_next = 1'b0;
    end else if (rise) begin
      shift_next  = {shift_reg[6:0], sdiSync};
      bitCnt_next = bitCnt_reg + 5'h01;
      if (!hdrDone_reg) begin
        if (bitCnt_reg == 5'h00) begin
          rdMode_next = sdiSync;
        end else begin
          addr_next = {addr_reg[13:0], sdiSync};
        end
        if (bitCnt_reg == 5'(scir_pkg::HDR_BITS - 1)) begin
          hdrDone_next = 1'b1;
          bitCnt_next  = 5'h00;
          out_next     = rdata; // byte at the incomplete address; the next fall loads the first read byte
        end
      end else if (bitCnt_reg == 5'h07) begin
        bitCnt_next = 5'h00;
        wbyte_next  = {shift_reg[6:0], sdiSync};
        stb_next    = ~rdMode_reg;
        step_next   = 1'b1; // address moves one cycle after the strobe
      end
    end else if (fall && hdrDone_reg) begin
      if (bitCnt_reg == 5'h00) begin
        out_next = rdata;
      end else begin
        out_next = {out_reg[6:0], 1'b0};
      end
    end
    // step only after the strobe has used the current address
    if (step_reg && !stepHold) begin
      addr_next = stepUp ? addr_reg + 15'h0001 : addr_reg - 15'h0001;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sclkDly_reg <= 1'b0;
      bitCnt_reg  <= 5'h00;
      hdrDone_reg <= 1'b0;
      rdMode_reg  <= 1'b0;
      addr_reg    <= 15'h0000;
      shift_reg   <= 8'h00;
      out_reg     <= 8'h00;
      stb_reg     <= 1'b0;
      wbyte_reg   <= 8'h00;
      step_reg    <= 1'b0;
    end else begin
      sclkDly_reg <= sclkDly_next;
      bitCnt_reg  <= bitCnt_next;
      hdrDone_reg <= hdrDone_next;
      rdMode_reg  <= rdMode_next;
      addr_reg    <= addr_next;
      shift_reg   <= shift_next;
      out_reg     <= out_next;
      stb_reg     <= stb_next;
      wbyte_reg   <= wbyte_next;
      step_reg    <= step_next;
    end
  end

  // write strobe carries the address that was just used
  assign accStb    = stb_reg;
  assign acc.wrEn  = stb_reg;
  assign acc.addr  = addr_reg;
  assign acc.wdata = wbyte_reg;
  assign sdoOut    = out_reg[7];
endmodule
`default_nettype wire

// ===== core/scir_regs.sv
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - writing one to config bit 7 resets chip and all serial registers
// - full-reset bit clears itself; reads always return zero
// - internal reset completes within 750 ns, then serial accesses resume
// - streaming address steps down when bit 5 is zero, up when one
// - bit 4 reads one; read data only on the dedicated serial output
// - mode field: 0 normal, 3 shutdown, 1 and 2 reserved
// - device-class low nibble is a fixed read-only code
// - 16-bit read-only identifier at address 4
// - interface configuration reads 0x30 after reset
// - address-freeze bit holds streaming address constant, else direction bit rules
module scir_regs #(
  parameter logic [3:0]  DEV_CLASS = 4'hA,    // arbitrary value
  parameter logic [15:0] DEV_ID    = 16'h5A5A // arbitrary value
) (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic spiSclk,
  input  wire logic spiCs_b,
  input  wire logic spiSdi,
  output logic      spiSdo,
  output logic      shutdown,
  output logic      resetBusy
);
  localparam logic [9:0] RST_CNT = 10'(scir_pkg::RESET_CYCLES);

  logic [1:0] sclkSy_reg, csSy_reg, sdiSy_reg;
  logic       softRst_b;
  logic [7:0] ifcfg_reg, ifcfg_next;
  logic [7:0] opmode_reg, opmode_next;
  logic [3:0] devclsRsv_reg, devclsRsv_next;
  logic [7:0] stepcfg_reg, stepcfg_next;
  logic [9:0] rstCnt_reg, rstCnt_next;
  logic       shutdown_reg, shutdown_next;
  logic       busy_reg, busy_next;
  logic       fire;
  logic [7:0] rdata;
  logic       accStb;
  logic       sdoRaw;
  logic       sdo_reg;
  scir_pkg::scir_acc_s acc;

  // read mux; full-reset bit and unmapped addresses read zero
  function automatic logic [7:0] readByte(input logic [14:0] a, input logic [7:0] cfg,
                                          input logic [7:0] om, input logic [3:0] rsv,
                                          input logic [7:0] sc);
    unique case (a)
      scir_pkg::ADDR_IFCFG:   readByte = {1'b0, cfg[6:0]} | scir_pkg::IFCFG_RO_MASK;
      scir_pkg::ADDR_OPMODE:  readByte = om;
      scir_pkg::ADDR_DEVCLS:  readByte = {rsv, DEV_CLASS};
      scir_pkg::ADDR_DEVID_H: readByte = DEV_ID[15:8];
      scir_pkg::ADDR_DEVID_L: readByte = DEV_ID[7:0];
      scir_pkg::ADDR_STEPCFG: readByte = sc;
      default:                readByte = 8'h00;
    endcase
  endfunction

  // pins from the host pass two flops; the link is slow against clk
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sclkSy_reg <= 2'h0;
      csSy_reg   <= 2'h3;
      sdiSy_reg  <= 2'h0;
    end else begin
      sclkSy_reg <= {sclkSy_reg[0], spiSclk};
      csSy_reg   <= {csSy_reg[0], spiCs_b};
      sdiSy_reg  <= {sdiSy_reg[0], spiSdi};
    end
  end

  assign rdata = readByte(acc.addr, ifcfg_reg, opmode_reg, devclsRsv_reg, stepcfg_reg);
  assign fire  = accStb && acc.addr == scir_pkg::ADDR_IFCFG && acc.wdata[scir_pkg::BIT_FULL_RESET];

  // serial engine is held in reset while the full reset runs
  assign softRst_b = rst_b & ~busy_reg;

  scir_spi_shift u_shift (
    .clk      (clk),
    .rst_b    (softRst_b),
    .sclkSync (sclkSy_reg[1]),
    .csSync_b (csSy_reg[1]),
    .sdiSync  (sdiSy_reg[1]),
    .stepUp   (ifcfg_reg[scir_pkg::BIT_ASCEND]),
    .stepHold (stepcfg_reg[scir_pkg::BIT_ADDR_FREEZE]),
    .rdata    (rdata),
    .acc      (acc),
    .accStb   (accStb),
    .sdoOut   (sdoRaw)
  );

  // register writes and full-reset sequencing
  always_comb begin
    ifcfg_next     = ifcfg_reg;
    opmode_next    = opmode_reg;
    devclsRsv_next = devclsRsv_reg;
    stepcfg_next   = stepcfg_reg;
    rstCnt_next    = rstCnt_reg;
    busy_next      = busy_reg;
    if (busy_reg) begin
      // everything returns to reset values while busy
      ifcfg_next     = scir_pkg::IFCFG_RESET;
      opmode_next    = scir_pkg::OPMODE_RESET;
      devclsRsv_next = scir_pkg::DEVCLS_RESET[7:4];
      stepcfg_next   = scir_pkg::STEPCFG_RESET;
      rstCnt_next    = rstCnt_reg - 10'h001;
      if (rstCnt_reg == 10'h001) begin
        busy_next = 1'b0;
      end
    end else if (fire) begin
      busy_next   = 1'b1;
      rstCnt_next = RST_CNT;
    end else if (accStb) begin
      unique case (acc.addr)
        scir_pkg::ADDR_IFCFG: ifcfg_next = {1'b0, acc.wdata[6:5], 1'b1, acc.wdata[3:0]};
        scir_pkg::ADDR_OPMODE: opmode_next = acc.wdata;
        scir_pkg::ADDR_DEVCLS: devclsRsv_next = acc.wdata[7:4];
        scir_pkg::ADDR_STEPCFG: stepcfg_next = acc.wdata;
        default: ;
      endcase
    end
  end

  // shutdown only on code 3; reserved codes keep normal operation
  always_comb begin
    shutdown_next = opmode_reg[1:0] == scir_pkg::MODE_SHUTDOWN;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ifcfg_reg     <= scir_pkg::IFCFG_RESET;
      opmode_reg    <= scir_pkg::OPMODE_RESET;
      devclsRsv_reg <= scir_pkg::DEVCLS_RESET[7:4];
      stepcfg_reg   <= scir_pkg::STEPCFG_RESET;
      rstCnt_reg    <= 10'h000;
      busy_reg      <= 1'b0;
      shutdown_reg  <= 1'b0;
      sdo_reg       <= 1'b0;
    end else begin
      ifcfg_reg     <= ifcfg_next;
      opmode_reg    <= opmode_next;
      devclsRsv_reg <= devclsRsv_next;
      stepcfg_reg   <= stepcfg_next;
      rstCnt_reg    <= rstCnt_next;
      busy_reg      <= busy_next;
      shutdown_reg  <= shutdown_next;
      sdo_reg       <= sdoRaw;
    end
  end

  assign spiSdo    = sdo_reg;
  assign shutdown  = shutdown_reg;
  assign resetBusy = busy_reg;
endmodule
`default_nettype wire

// ===== test/scir_regs_sva.sv
`timescale 1ns/1ns
`default_nettype none
module scir_regs_sva (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic spiSclk,
  input wire logic spiCs_b,
  input wire logic spiSdi,
  input wire logic spiSdo,
  input wire logic shutdown,
  input wire logic resetBusy
);
  logic [7:0] busyCnt_reg;
  logic [7:0] busyCnt_next;
  // length of the running full-reset interval
  always_comb begin
    busyCnt_next = resetBusy ? busyCnt_reg + 8'h01 : 8'h00;
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) busyCnt_reg <= 8'h00;
    else busyCnt_reg <= busyCnt_next;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_busy_len; $fell(resetBusy) |-> busyCnt_reg == scir_pkg::RESET_CYCLES; endproperty
  a_busy_len: assert property (p_busy_len) else $error("reset interval length wrong");
  property p_busy_max; busyCnt_reg <= scir_pkg::RESET_CYCLES; endproperty
  a_busy_max: assert property (p_busy_max) else $error("reset interval too long");
  property p_busy_span; $rose(resetBusy) |=> resetBusy [*8]; endproperty
  a_busy_span: assert property (p_busy_span) else $error("reset interval cut short");
  property p_busy_rise; spiCs_b [*4] |-> !$rose(resetBusy); endproperty
  a_busy_rise: assert property (p_busy_rise) else $error("reset began with no frame");
  property p_shut_stable; spiCs_b [*4] |-> $stable(shutdown); endproperty
  a_shut_stable: assert property (p_shut_stable) else $error("mode changed between frames");
  property p_busy_shut; resetBusy [*3] |-> !shutdown; endproperty
  a_busy_shut: assert property (p_busy_shut) else $error("mode kept over full reset");
  property p_busy_sdo; resetBusy [*3] |-> !spiSdo; endproperty
  a_busy_sdo: assert property (p_busy_sdo) else $error("serial output active in reset");
  // the output may only move shortly after a serial clock edge
  property p_sdo_hold; (!spiCs_b && $stable(spiSclk)) [*8] |-> $stable(spiSdo); endproperty
  a_sdo_hold: assert property (p_sdo_hold) else $error("serial output moved while idle");
  c_busy: cover property ($rose(resetBusy));
  c_shut: cover property ($rose(shutdown));
  c_sdo: cover property ($rose(spiSdo));
endmodule
bind scir_regs scir_regs_sva u_sva (.clk(clk), .rst_b(rst_b), .spiSclk(spiSclk), .spiCs_b(spiCs_b),
  .spiSdi(spiSdi), .spiSdo(spiSdo), .shutdown(shutdown), .resetBusy(resetBusy));
`default_nettype wire

// ===== test/scir_spi_host.sv
`timescale 1ns/1ns
`default_nettype none
module scir_spi_host (
  input  wire logic clk,
  output var  logic spiSclk,
  output var  logic spiCs_b,
  output var  logic spiSdi,
  input  wire logic spiSdo
);
  localparam int HALF = 6; // margin over the 4-cycle minimum half period
  initial begin
    spiSclk = 1'b0;
    spiCs_b = 1'b1;
    spiSdi = 1'b0;
  end
  // one mode 0 frame: header then n bytes, read data from the serial output only
  task automatic xfer(input logic rd, input logic [14:0] a, input int n, input logic [23:0] wd,
                      output logic [23:0] q);
    logic [39:0] sh;
    sh = {rd, a, wd};
    q = 24'h000000;
    @(negedge clk);
    spiCs_b = 1'b0;
    for (int i = 0; i < 16 + 8 * n; i++) begin
      spiSdi = sh[39 - i];
      repeat (HALF) @(negedge clk);
      spiSclk = 1'b1;
      if (i >= 16) q = {q[22:0], spiSdo};
      repeat (HALF) @(negedge clk);
      spiSclk = 1'b0;
    end
    repeat (10) @(negedge clk); // let the last byte land before release
    spiCs_b = 1'b1;
    spiSdi = ~spiSdi; // released line shows no stale bit
    repeat (4) @(negedge clk);
  endtask
endmodule
`default_nettype wire

// ===== test/tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; $display("mismatch %s exp %h seen %h", nm, e, g); end end
module tb;
  typedef struct packed {logic [14:0] addr; logic [7:0] wd; logic [7:0] rexp; logic shut;} scir_row_s;
  localparam logic [3:0]  DEV_CLASS = 4'h6;   // arbitrary value
  localparam logic [15:0] DEV_ID    = 16'hC3E1; // arbitrary value
  logic        clk, rst_b, spiSclk, spiCs_b, spiSdi, spiSdo, shutdown, resetBusy;
  logic [23:0] q;
  int          fail_count, tests_run, n;
  scir_row_s   rows [10];
  scir_regs #(.DEV_CLASS(DEV_CLASS), .DEV_ID(DEV_ID)) DUT (.clk(clk), .rst_b(rst_b), .spiSclk(spiSclk),
    .spiCs_b(spiCs_b), .spiSdi(spiSdi), .spiSdo(spiSdo), .shutdown(shutdown), .resetBusy(resetBusy));
  scir_spi_host host (.clk(clk), .spiSclk(spiSclk), .spiCs_b(spiCs_b), .spiSdi(spiSdi), .spiSdo(spiSdo));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    host.xfer(1'b0, a, 1, {d, 16'h0000}, q);
  endtask
  task automatic rd(input logic [14:0] a, input int nb);
    host.xfer(1'b1, a, nb, 24'h000000, q);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // watchdog well past the expected run of about 9500 cycles
  initial begin
    repeat (60000) @(posedge clk);
    fail_count++;
    print_verdict();
  end
  initial begin
    rst_b = 1'b0;
    fail_count = 0;
    tests_run = 0;
    rows = '{'{scir_pkg::ADDR_OPMODE, 8'h03, 8'h03, 1'b1}, '{scir_pkg::ADDR_OPMODE, 8'h01, 8'h01, 1'b0},
      '{scir_pkg::ADDR_OPMODE, 8'hFE, 8'hFE, 1'b0}, '{scir_pkg::ADDR_OPMODE, 8'h00, 8'h00, 1'b0},
      '{scir_pkg::ADDR_DEVCLS, 8'hFF, {4'hF, DEV_CLASS}, 1'b0}, '{scir_pkg::ADDR_DEVID_H, 8'h00, DEV_ID[15:8], 1'b0},
      '{scir_pkg::ADDR_DEVID_L, 8'hFF, DEV_ID[7:0], 1'b0}, '{scir_pkg::ADDR_STEPCFG, 8'hFE, 8'hFE, 1'b0},
      '{15'h0007, 8'h55, 8'h00, 1'b0}, '{scir_pkg::ADDR_IFCFG, 8'h4F, 8'h5F, 1'b0}};
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    rd(scir_pkg::ADDR_IFCFG, 1);
    `CHK("ifcfg", 8'h30, q[7:0])
    rd(scir_pkg::ADDR_DEVCLS, 1);
    `CHK("class", {4'h0, DEV_CLASS}, q[7:0])
    rd(scir_pkg::ADDR_DEVID_H, 2);
    `CHK("id up", DEV_ID, q[15:0])
    $display("test reset values done");
    // write then read back each row; last row turns stepping downward
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wd);
      `CHK("shutdown", rows[i].shut, shutdown)
      rd(rows[i].addr, 1);
      `CHK("readback", rows[i].rexp, q[7:0])
    end
    $display("test table done");
    rd(scir_pkg::ADDR_DEVID_L, 2);
    `CHK("id down", {DEV_ID[7:0], DEV_ID[15:8]}, q[15:0])
    wr(scir_pkg::ADDR_STEPCFG, 8'h01);
    rd(scir_pkg::ADDR_DEVID_H, 3);
    `CHK("frozen", {3{DEV_ID[15:8]}}, q)
    $display("test stepping done");
    wr(scir_pkg::ADDR_OPMODE, 8'h03);
    wr(scir_pkg::ADDR_IFCFG, 8'h80);
    `CHK("busy", 1'b1, resetBusy)
    n = 0;
    while (resetBusy === 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    `CHK("busy short", 1'b1, n < scir_pkg::RESET_CYCLES)
    `CHK("shut off", 1'b0, shutdown)
    // no frame while the reset runs, then a frame gap
    repeat (4) @(negedge clk);
    rd(scir_pkg::ADDR_IFCFG, 1);
    `CHK("ifcfg again", 8'h30, q[7:0])
    rd(scir_pkg::ADDR_STEPCFG, 1);
    `CHK("step cleared", 8'h00, q[7:0])
    $display("test full reset done");
    print_verdict();
  end
endmodule
`default_nettype wire
